// File: hw/tmr_pkg.sv
// Register map, field positions and timing constants of the timer 2 block.
package tmr_pkg;
    // Register indices; the byte address on the bus is four times the index.
    localparam logic [7:0] IDX_CONTROL      = 8'hC8;
    localparam logic [7:0] IDX_MODE_CONTROL = 8'hC9;
    localparam logic [7:0] IDX_CAPTURE_LOW  = 8'hCA;
    localparam logic [7:0] IDX_CAPTURE_HIGH = 8'hCB;
    localparam logic [7:0] IDX_COUNT_LOW    = 8'hCC;
    localparam logic [7:0] IDX_COUNT_HIGH   = 8'hCD;

    // Control register fields.
    localparam int CTL_TIMER_OVERFLOW_FLAG = 7;
    localparam int CTL_EXTERNAL_EDGE_FLAG  = 6;
    localparam int CTL_RX_BAUD_SELECT      = 5;
    localparam int CTL_TX_BAUD_SELECT      = 4;
    localparam int CTL_EDGE_INPUT_ENABLE   = 3;
    localparam int CTL_RUN_CONTROL         = 2;
    localparam int CTL_COUNT_SOURCE_SELECT = 1;
    localparam int CTL_CAPTURE_RELOAD_SEL  = 0;

    // Mode control register fields.
    localparam int MOD_CAPTURE_AUTO_CLEAR  = 3;
    localparam int MOD_CLOCK_OUT_ENABLE    = 1;
    localparam int MOD_DOWN_COUNT_ENABLE   = 0;

    // Reset values and the full count.
    localparam logic [7:0]  RESET_BYTE  = 8'h00;
    localparam logic [15:0] RESET_COUNT = 16'h0000;
    localparam logic [15:0] COUNT_FULL  = 16'hFFFF;

    // Core clocks per tick: slow rate, fast rate, baud-rate generator.
    localparam logic [3:0] TICK_DIV_SLOW = 4'hC;
    localparam logic [3:0] TICK_DIV_FAST = 4'h4;
    localparam logic [3:0] TICK_DIV_BAUD = 4'h2;

    // Bus responses.
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// File: hw/tmr_timer2.sv
// Timer 2: capture, auto-reload and baud generation behind an AXI4-Lite slave.
`timescale 1ns/100ps
`default_nettype none

// Operation
// RL1: Set overflow flag when the sixteen-bit count overflows with both baud selects 0.
// RL2: Counting down, set overflow flag when count equals the capture register.
// RL3: Hardware sets overflow flag only with both baud selects 0; software clears.
// RL4: Edge flag set by input falling edge or overflow per mode bits.
// RL5: Edge flag set by software or edge raises the enabled timer interrupt.
// RL6: Receive baud select picks receive time-base; setting forces baud mode.
// RL7: Transmit baud select picks transmit time-base; setting forces baud mode.
// RL8: Edge enable 0 ignores the edge pin; otherwise edge captures or reloads.
// RL9: Run control enables counting; cleared it freezes the count.
// RL10: Source select 0 counts core ticks at chosen rate, 1 counts pin edges.
// RL11: In baud mode the timer advances every two clocks.
// RL12: Any baud select forces auto-reload after every overflow.
// RL13: Reload select reloads on overflow and on enabled input falling edge.
// RL14: Capture select with edge enable captures the count on falling edge.
// RL15: Capture with auto-clear set resets the count after capturing.
// RL16: Clock out enable switches the clock output on or off.
// RL17: In auto-reload, down enable and edge pin level choose direction.
// RL18: Capture low byte receives count low byte or supplies reload low byte.
// RL19: Capture high byte receives count high byte or supplies reload high byte.
// RL20: Down enabled: pin high counts up, low counts down; reload on up overflow.
module tmr_timer2
    import tmr_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    // Clock and reset.
    input  wire logic              clock_in,
    input  wire logic              resetn_in,
    // AXI4-Lite write channels.
    input  wire logic [ADDR_W-1:0] s_axi_awaddr_in,
    input  wire logic              s_axi_awvalid_in,
    output var  logic              s_axi_awready_out,
    input  wire logic [31:0]       s_axi_wdata_in,
    input  wire logic [3:0]        s_axi_wstrb_in,
    input  wire logic              s_axi_wvalid_in,
    output var  logic              s_axi_wready_out,
    output var  logic [1:0]        s_axi_bresp_out,
    output var  logic              s_axi_bvalid_out,
    input  wire logic              s_axi_bready_in,
    // AXI4-Lite read channels.
    input  wire logic [ADDR_W-1:0] s_axi_araddr_in,
    input  wire logic              s_axi_arvalid_in,
    output var  logic              s_axi_arready_out,
    output var  logic [31:0]       s_axi_rdata_out,
    output var  logic [1:0]        s_axi_rresp_out,
    output var  logic              s_axi_rvalid_out,
    input  wire logic              s_axi_rready_in,
    // Pins.
    input  wire logic              count_input_pin_in,
    input  wire logic              edge_input_pin_in,
    output var  logic              clock_out_out,
    // Core and serial port side.
    input  wire logic              timer_rate_select_in,
    input  wire logic              timer1_overflow_in,
    input  wire logic              timer_irq_enable_in,
    output var  logic              rx_baud_tick_out,
    output var  logic              tx_baud_tick_out,
    output var  logic              timer_irq_out
);

    // The six register indices need eight index bits above the byte lanes.
    if (ADDR_W < 10) begin : g_addr_check
        $error("ADDR_W too small for the register map");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register state.
    logic        timer_overflow_flag;
    logic        external_edge_flag;
    logic        rx_baud_select;
    logic        tx_baud_select;
    logic        edge_input_enable;
    logic        run_control;
    logic        count_source_select;
    logic        capture_reload_select;
    logic        capture_auto_clear;
    logic        clock_out_enable;
    logic        down_count_enable;
    logic [15:0] count;
    logic [15:0] capture;

    function automatic logic idx_is(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
        return (a[ADDR_W-1:2] == (ADDR_W-2)'(idx));
    endfunction

    function automatic logic idx_mapped(input logic [ADDR_W-1:0] a);
        return idx_is(a, IDX_CONTROL) || idx_is(a, IDX_MODE_CONTROL)
            || idx_is(a, IDX_CAPTURE_LOW) || idx_is(a, IDX_CAPTURE_HIGH)
            || idx_is(a, IDX_COUNT_LOW) || idx_is(a, IDX_COUNT_HIGH);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; a level counts once stages two and three agree.
    logic [2:0] cnt_sync;
    logic [2:0] edg_sync;
    logic       cnt_level;
    logic       edg_level;
    logic       cnt_fall;
    logic       edg_fall;

    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cnt_sync  <= 3'h7;
            edg_sync  <= 3'h7;
            cnt_level <= 1'b1;
            edg_level <= 1'b1;
        end else begin
            cnt_sync <= {cnt_sync[1:0], count_input_pin_in};
            edg_sync <= {edg_sync[1:0], edge_input_pin_in};
            if (cnt_sync[1] == cnt_sync[2]) begin
                cnt_level <= cnt_sync[2];
            end
            if (edg_sync[1] == edg_sync[2]) begin
                edg_level <= edg_sync[2];
            end
        end
    end

    assign cnt_fall = cnt_level && (cnt_sync[1] == cnt_sync[2]) && !cnt_sync[2];
    assign edg_fall = edg_level && (edg_sync[1] == edg_sync[2]) && !edg_sync[2];

    ////////////////////////////////////////////////////////////////////////////
    // Tick generation.
    logic       baud_mode;
    logic [3:0] presc;
    logic [3:0] presc_limit;
    logic       presc_hit;
    logic       tick;

    assign baud_mode   = rx_baud_select || tx_baud_select; // RL6 RL7
    assign presc_limit = baud_mode ? TICK_DIV_BAUD - 4'h1 // RL11
                       : timer_rate_select_in ? TICK_DIV_FAST - 4'h1
                       : TICK_DIV_SLOW - 4'h1; // RL10
    assign presc_hit   = (presc >= presc_limit);

    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            presc <= 4'h0;
        end else if (!run_control || presc_hit) begin
            presc <= 4'h0;
        end else begin
            presc <= presc + 4'h1;
        end
    end

    // Baud mode ignores the source select; counter mode uses pin edges.
    assign tick = run_control && (baud_mode ? presc_hit // RL9 RL11
                : count_source_select ? cnt_fall : presc_hit); // RL10

    ////////////////////////////////////////////////////////////////////////////
    // Counting, capture and reload.
    logic        edge_event;
    logic        down_mode;
    logic [15:0] next_count;
    logic        tf_hw;
    logic        exf_hw;
    logic        cap_hw;
    logic        ovf;

    assign edge_event = edg_fall && edge_input_enable; // RL8
    assign down_mode  = !baud_mode && !capture_reload_select && down_count_enable;

    always_comb begin
        next_count = count;
        tf_hw      = 1'b0;
        exf_hw     = 1'b0;
        cap_hw     = 1'b0;
        ovf        = 1'b0;
        if (tick) begin
            if (baud_mode || !capture_reload_select) begin // RL12
                if (down_mode && !edg_level) begin // RL17 RL20
                    if (count == capture) begin
                        next_count = COUNT_FULL;
                        tf_hw      = 1'b1; // RL2
                        exf_hw     = 1'b1; // RL4
                        ovf        = 1'b1;
                    end else begin
                        next_count = count - 16'h0001;
                    end
                end else if (count == COUNT_FULL) begin
                    next_count = capture; // RL13 RL18 RL19 RL20
                    tf_hw      = !baud_mode; // RL1 RL3
                    exf_hw     = down_mode; // RL4
                    ovf        = 1'b1;
                end else begin
                    next_count = count + 16'h0001;
                end
            end else if (count == COUNT_FULL) begin
                next_count = RESET_COUNT;
                tf_hw      = 1'b1; // RL1
                ovf        = 1'b1;
            end else begin
                next_count = count + 16'h0001;
            end
        end
        if (edge_event && !baud_mode) begin // RL8
            if (capture_reload_select) begin
                cap_hw = 1'b1; // RL14
                if (capture_auto_clear) begin
                    next_count = RESET_COUNT; // RL15
                end
            end else if (!down_count_enable) begin
                next_count = capture; // RL13
            end
        end
        // The pin sets the edge flag except while it steers the direction.
        if (edge_event && !down_mode) begin
            exf_hw = 1'b1; // RL4
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave; address and data are taken in either order.
    logic              aw_held;
    logic              w_held;
    logic [ADDR_W-1:0] aw_addr;
    logic [31:0]       w_data;
    logic              w_lane0;
    logic              wr_go;
    logic              wr_ok;
    logic              wr_ctrl;
    logic              wr_mode;
    logic              wr_cap_lo;
    logic              wr_cap_hi;
    logic              wr_cnt_lo;
    logic              wr_cnt_hi;

    assign wr_go     = aw_held && w_held && !s_axi_bvalid_out;
    assign wr_ok     = wr_go && w_lane0;
    assign wr_ctrl   = wr_ok && idx_is(aw_addr, IDX_CONTROL);
    assign wr_mode   = wr_ok && idx_is(aw_addr, IDX_MODE_CONTROL);
    assign wr_cap_lo = wr_ok && idx_is(aw_addr, IDX_CAPTURE_LOW);
    assign wr_cap_hi = wr_ok && idx_is(aw_addr, IDX_CAPTURE_HIGH);
    assign wr_cnt_lo = wr_ok && idx_is(aw_addr, IDX_COUNT_LOW);
    assign wr_cnt_hi = wr_ok && idx_is(aw_addr, IDX_COUNT_HIGH);

    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            aw_held           <= 1'b0;
            w_held            <= 1'b0;
            aw_addr           <= '0;
            w_data            <= 32'h00000000;
            w_lane0           <= 1'b0;
            s_axi_awready_out <= 1'b0;
            s_axi_wready_out  <= 1'b0;
            s_axi_bvalid_out  <= 1'b0;
            s_axi_bresp_out   <= RESP_OKAY;
        end else begin
            s_axi_awready_out <= !aw_held && !s_axi_awready_out && !s_axi_bvalid_out;
            s_axi_wready_out  <= !w_held && !s_axi_wready_out && !s_axi_bvalid_out;
            if (s_axi_awvalid_in && s_axi_awready_out) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr_in;
                s_axi_awready_out <= 1'b0;
            end
            if (s_axi_wvalid_in && s_axi_wready_out) begin
                w_held  <= 1'b1;
                w_data  <= s_axi_wdata_in;
                w_lane0 <= s_axi_wstrb_in[0];
                s_axi_wready_out <= 1'b0;
            end
            if (wr_go) begin
                aw_held          <= 1'b0;
                w_held           <= 1'b0;
                s_axi_bvalid_out <= 1'b1;
                s_axi_bresp_out  <= idx_mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bvalid_out && s_axi_bready_in) begin
                s_axi_bvalid_out <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            s_axi_arready_out <= 1'b0;
            s_axi_rvalid_out  <= 1'b0;
            s_axi_rdata_out   <= 32'h00000000;
            s_axi_rresp_out   <= RESP_OKAY;
        end else if (s_axi_arvalid_in && s_axi_arready_out) begin
            s_axi_arready_out <= 1'b0;
            s_axi_rvalid_out  <= 1'b1;
            s_axi_rresp_out   <= idx_mapped(s_axi_araddr_in) ? RESP_OKAY : RESP_SLVERR;
            s_axi_rdata_out   <= 32'h00000000;
            if (idx_is(s_axi_araddr_in, IDX_CONTROL)) begin
                s_axi_rdata_out[7:0] <= {timer_overflow_flag, external_edge_flag,
                    rx_baud_select, tx_baud_select, edge_input_enable, run_control,
                    count_source_select, capture_reload_select};
            end else if (idx_is(s_axi_araddr_in, IDX_MODE_CONTROL)) begin
                s_axi_rdata_out[7:0] <= {4'h0, capture_auto_clear, 1'b0,
                    clock_out_enable, down_count_enable};
            end else if (idx_is(s_axi_araddr_in, IDX_CAPTURE_LOW)) begin
                s_axi_rdata_out[7:0] <= capture[7:0];
            end else if (idx_is(s_axi_araddr_in, IDX_CAPTURE_HIGH)) begin
                s_axi_rdata_out[7:0] <= capture[15:8];
            end else if (idx_is(s_axi_araddr_in, IDX_COUNT_LOW)) begin
                s_axi_rdata_out[7:0] <= count[7:0];
            end else if (idx_is(s_axi_araddr_in, IDX_COUNT_HIGH)) begin
                s_axi_rdata_out[7:0] <= count[15:8];
            end
        end else if (s_axi_rvalid_out) begin
            if (s_axi_rready_in) begin
                s_axi_rvalid_out <= 1'b0;
            end
        end else begin
            s_axi_arready_out <= !s_axi_arready_out;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control and mode registers; a hardware set beats a software clear.
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            timer_overflow_flag   <= 1'b0;
            external_edge_flag    <= 1'b0;
            rx_baud_select        <= 1'b0;
            tx_baud_select        <= 1'b0;
            edge_input_enable     <= 1'b0;
            run_control           <= 1'b0;
            count_source_select   <= 1'b0;
            capture_reload_select <= 1'b0;
            capture_auto_clear    <= 1'b0;
            clock_out_enable      <= 1'b0;
            down_count_enable     <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                timer_overflow_flag   <= w_data[CTL_TIMER_OVERFLOW_FLAG] || tf_hw; // RL3
                external_edge_flag    <= w_data[CTL_EXTERNAL_EDGE_FLAG] || exf_hw; // RL5
                rx_baud_select        <= w_data[CTL_RX_BAUD_SELECT];
                tx_baud_select        <= w_data[CTL_TX_BAUD_SELECT];
                edge_input_enable     <= w_data[CTL_EDGE_INPUT_ENABLE];
                run_control           <= w_data[CTL_RUN_CONTROL];
                count_source_select   <= w_data[CTL_COUNT_SOURCE_SELECT];
                capture_reload_select <= w_data[CTL_CAPTURE_RELOAD_SEL];
            end else begin
                timer_overflow_flag <= timer_overflow_flag || tf_hw; // RL1 RL2
                external_edge_flag  <= external_edge_flag || exf_hw; // RL4
            end
            if (wr_mode) begin
                capture_auto_clear <= w_data[MOD_CAPTURE_AUTO_CLEAR];
                clock_out_enable   <= w_data[MOD_CLOCK_OUT_ENABLE];
                down_count_enable  <= w_data[MOD_DOWN_COUNT_ENABLE];
            end
        end
    end

    // Software writes to the count take priority over the running count.
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            count <= RESET_COUNT;
        end else begin
            count <= next_count; // RL9
            if (wr_cnt_lo) begin
                count[7:0] <= w_data[7:0];
            end
            if (wr_cnt_hi) begin
                count[15:8] <= w_data[7:0];
            end
        end
    end

    // A capture from the pin wins over a software write in the same cycle.
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            capture <= RESET_COUNT;
        end else if (cap_hw) begin
            capture <= count; // RL14 RL18 RL19
        end else begin
            if (wr_cap_lo) begin
                capture[7:0] <= w_data[7:0];
            end
            if (wr_cap_hi) begin
                capture[15:8] <= w_data[7:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs towards the serial port, the pin and the interrupt logic.
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rx_baud_tick_out <= 1'b0;
            tx_baud_tick_out <= 1'b0;
            clock_out_out    <= 1'b0;
            timer_irq_out    <= 1'b0;
        end else begin
            rx_baud_tick_out <= rx_baud_select ? ovf : timer1_overflow_in; // RL6
            tx_baud_tick_out <= tx_baud_select ? ovf : timer1_overflow_in; // RL7
            if (!clock_out_enable) begin
                clock_out_out <= 1'b0; // RL16
            end else if (ovf) begin
                clock_out_out <= !clock_out_out; // RL16
            end
            timer_irq_out <= timer_irq_enable_in
                && (timer_overflow_flag || external_edge_flag); // RL5
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks.
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!resetn_in);

    a_tf_on_overflow: assert property ( // RL1
        (tick && !baud_mode && capture_reload_select && count == COUNT_FULL)
        |=> timer_overflow_flag && count == RESET_COUNT)
        else $error("overflow did not set the flag");
    a_tf_down_equal: assert property ( // RL2
        (tick && down_mode && !edg_level && count == capture)
        |=> timer_overflow_flag && count == COUNT_FULL)
        else $error("down count match did not set the flag");
    a_tf_baud_hold: assert property ( // RL3
        (baud_mode && !wr_ctrl && !timer_overflow_flag) |=> !timer_overflow_flag)
        else $error("flag set by hardware in baud mode");
    a_edge_capture: assert property ( // RL14
        (edge_event && capture_reload_select && !baud_mode)
        |=> capture == $past(count))
        else $error("edge did not capture the count");
    a_stop_holds: assert property ( // RL9
        (!run_control && !wr_cnt_lo && !wr_cnt_hi && !edge_event)
        |=> count == $past(count))
        else $error("stopped timer changed its count");
    a_baud_rate: assert property ( // RL11
        (tick && baud_mode && run_control) ##1 (baud_mode && run_control && !tick)
        |=> tick)
        else $error("baud tick not every two clocks");
    a_auto_clear: assert property ( // RL15
        (cap_hw && capture_auto_clear && !wr_cnt_lo && !wr_cnt_hi)
        |=> count == RESET_COUNT)
        else $error("capture did not clear the count");
    a_exf_edge: assert property ( // RL4
        (edge_event && !down_mode) |=> external_edge_flag)
        else $error("edge did not set the edge flag");
    a_rx_select: assert property ( // RL6
        rx_baud_tick_out == ($past(rx_baud_select) ? $past(ovf) : $past(timer1_overflow_in)))
        else $error("receive time-base wrong");
    a_edge_ignored: assert property ( // RL8
        (!edge_input_enable && !tick && !wr_cnt_lo && !wr_cnt_hi && !wr_cap_lo
         && !wr_cap_hi) |=> count == $past(count) && capture == $past(capture))
        else $error("edge pin acted while disabled");
    a_reload_edge: assert property ( // RL13
        (edge_event && !baud_mode && !capture_reload_select && !down_count_enable
         && !wr_cnt_lo && !wr_cnt_hi) |=> count == $past(capture))
        else $error("edge did not reload");

    c_capture: cover property (cap_hw);
    c_down_match: cover property (tick && down_mode && !edg_level && count == capture);
    c_baud_tick: cover property (rx_baud_tick_out && rx_baud_select);
    c_clock_out: cover property (clock_out_enable && $rose(clock_out_out));

endmodule

`default_nettype wire

// File: verif/tmr_pins_model.sv
// Pin partner: count and edge pins pulsed low together on request.
`timescale 1ns/100ps
`default_nettype none
module tmr_pins_model (
    input  wire logic clock_in,
    input  wire logic fall_req_in,
    output var  logic count_pin_out,
    output var  logic edge_pin_out
);
    logic [2:0] low_cnt = 3'h0;
    assign count_pin_out = edge_pin_out;
    // Low while requested and six clocks after, so the synchronisers see a clean edge.
    always_ff @(posedge clock_in) begin
        if (fall_req_in) low_cnt <= 3'h6;
        else if (low_cnt != 3'h0) low_cnt <= low_cnt - 3'h1;
    end
    assign edge_pin_out = (low_cnt == 3'h0);
endmodule
`default_nettype wire

// File: verif/timer2_capture_reload_baud_bench.sv
// Bench for timer 2: bus tasks, pin partner and scenario checks.
`timescale 1ns/100ps
`default_nettype none
module timer2_capture_reload_baud_bench;
    import tmr_pkg::*;
    logic        clk = 0, rst_n = 0, awv = 0, wv = 0, brd = 0, arv = 0, rrd = 0, fall = 0;
    logic [11:0] aw = 0, ar = 0;
    logic [31:0] wd = 0;
    wire logic   awr, wr_r, bv, arr, rv, irq, rxt, txt, co, e_pin, c_pin;
    wire logic [1:0]  rr;
    wire logic [31:0] rdat;
    int          n_errors = 0, tests_run = 0, k;
    integer      seed = 52080;
    logic [7:0]  rl, c;
    tmr_timer2 tmr_timer2_i (.clock_in(clk), .resetn_in(rst_n), .s_axi_awaddr_in(aw),
        .s_axi_awvalid_in(awv), .s_axi_awready_out(awr), .s_axi_wdata_in(wd),
        .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wv), .s_axi_wready_out(wr_r),
        .s_axi_bresp_out(), .s_axi_bvalid_out(bv), .s_axi_bready_in(brd),
        .s_axi_araddr_in(ar), .s_axi_arvalid_in(arv), .s_axi_arready_out(arr),
        .s_axi_rdata_out(rdat), .s_axi_rresp_out(rr), .s_axi_rvalid_out(rv),
        .s_axi_rready_in(rrd), .count_input_pin_in(c_pin), .edge_input_pin_in(e_pin),
        .clock_out_out(co), .timer_rate_select_in(1'b1), .timer1_overflow_in(1'b0),
        .timer_irq_enable_in(1'b1), .rx_baud_tick_out(rxt), .tx_baud_tick_out(txt),
        .timer_irq_out(irq));
    tmr_pins_model tmr_pins_model_i (.clock_in(clk), .fall_req_in(fall),
        .count_pin_out(c_pin), .edge_pin_out(e_pin));
    initial forever #12.5 clk = ~clk;
    task automatic complete_run(input int e);
        n_errors += e;
        if (n_errors == 0 && tests_run > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [33:0] s, e);
        tests_run++;
        if (s !== e) begin
            n_errors++;
            $display("BAD %0t seen %h want %h", $time, s, e);
        end
    endtask
    task automatic wr(input logic [7:0] i, d);
        aw <= {2'b00, i, 2'b00};
        wd <= {24'h0, d};
        awv <= 1;
        wv <= 1;
        brd <= 1;
        for (k = 0; k < 40; k++) begin
            @(posedge clk);
            if (awr === 1'b1) awv <= 0;
            if (wr_r === 1'b1) wv <= 0;
            if (bv === 1'b1) break;
        end
        brd <= 0;
        if (k == 40) complete_run(1);
    endtask
    task automatic rd(input logic [7:0] i, d, input logic [1:0] r);
        ar <= {2'b00, i, 2'b00};
        arv <= 1;
        rrd <= 1;
        for (k = 0; k < 40; k++) begin
            @(posedge clk);
            if (arr === 1'b1) arv <= 0;
            if (rv === 1'b1) break;
        end
        rrd <= 0;
        if (k == 40) complete_run(1);
        chk({rr, rdat}, {r, 24'h0, d});
    endtask
    task automatic wt(input int sel);
        for (k = 0; k < 300; k++) begin
            @(posedge clk);
            if ((sel ? rxt && txt : irq) === 1'b1) break;
        end
        if (k == 300) complete_run(1);
    endtask
    task automatic pulse();
        fall <= 1;
        @(posedge clk);
        fall <= 0;
        repeat (20) @(posedge clk);
    endtask
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1;
        @(posedge clk);
        rd(IDX_CONTROL, 8'h00, RESP_OKAY);
        rd(IDX_MODE_CONTROL, 8'h00, RESP_OKAY);
        rd(8'h10, 8'h00, RESP_SLVERR);
        rl = 8'($random(seed)) & 8'h7F;
        c = 8'($random(seed));
        wr(IDX_CAPTURE_LOW, rl);
        wr(IDX_CAPTURE_HIGH, 8'hA5);
        wr(IDX_COUNT_LOW, 8'hFE);
        wr(IDX_COUNT_HIGH, 8'hFF);
        wr(IDX_CONTROL, 8'h04);
        wt(0);
        wr(IDX_CONTROL, 8'h80);
        rd(IDX_CONTROL, 8'h80, RESP_OKAY);
        rd(IDX_COUNT_HIGH, 8'hA5, RESP_OKAY);
        wr(IDX_COUNT_LOW, 8'h3C);
        repeat (40) @(posedge clk);
        rd(IDX_COUNT_LOW, 8'h3C, RESP_OKAY);
        wr(IDX_CONTROL, 8'h00);
        rd(IDX_CONTROL, 8'h00, RESP_OKAY);
        wr(IDX_COUNT_HIGH, c);
        wr(IDX_CONTROL, 8'h05);
        pulse();
        rd(IDX_CAPTURE_HIGH, 8'hA5, RESP_OKAY);
        wr(IDX_CONTROL, 8'h0D);
        pulse();
        rd(IDX_CAPTURE_HIGH, c, RESP_OKAY);
        rd(IDX_CONTROL, 8'h4D, RESP_OKAY);
        chk(irq, 1);
        wr(IDX_CONTROL, 8'h00);
        wr(IDX_COUNT_LOW, 8'hFE);
        wr(IDX_COUNT_HIGH, 8'hFF);
        wr(IDX_CONTROL, 8'h34);
        wt(1);
        wr(IDX_CONTROL, 8'h30);
        rd(IDX_CONTROL, 8'h30, RESP_OKAY);
        rd(IDX_COUNT_HIGH, c, RESP_OKAY);
        wr(IDX_MODE_CONTROL, 8'h08);
        wr(IDX_CONTROL, 8'h0D);
        pulse();
        wr(IDX_CONTROL, 8'h00);
        rd(IDX_COUNT_HIGH, 8'h00, RESP_OKAY);
        fall <= 1;
        wr(IDX_CAPTURE_LOW, rl);
        wr(IDX_CAPTURE_HIGH, 8'hA5);
        wr(IDX_COUNT_LOW, rl + 8'h01);
        wr(IDX_COUNT_HIGH, 8'hA5);
        wr(IDX_MODE_CONTROL, 8'h03);
        wr(IDX_CONTROL, 8'h04);
        wt(0);
        chk(co, 1);
        rd(IDX_CONTROL, 8'hC4, RESP_OKAY);
        rd(IDX_COUNT_HIGH, 8'hFF, RESP_OKAY);
        wr(IDX_CONTROL, 8'h00);
        fall <= 0;
        wr(IDX_MODE_CONTROL, 8'h00);
        wr(IDX_COUNT_LOW, 8'h10);
        wr(IDX_CONTROL, 8'h06);
        pulse();
        pulse();
        rd(IDX_COUNT_LOW, 8'h12, RESP_OKAY);
        wr(IDX_CONTROL, 8'h0C);
        pulse();
        rd(IDX_COUNT_HIGH, 8'hA5, RESP_OKAY);
        complete_run(0);
    end
endmodule
`default_nettype wire
